// *** core/dfs_pkg.sv ***
/*
  Package for the degauss and fault supervisor: register map, field
  positions, reset values, timing figures and the cycle counts derived
  from them. Assumes a 50 MHz system clock.
*/
package dfs_pkg;

  // Clock period in ns
  localparam int CLK_NS = 20;

  // Timing figures in their own units
  localparam int QUAL_NS        = 25600;
  localparam int DEMAG_MS       = 110;
  localparam int ON_DEMAG_US    = 12;
  localparam int ON_RUN_US      = 32;
  localparam int ABORT_FILT_US  = 25;
  localparam int HOLD_US        = 3300;
  localparam int HALF_MIN_NS    = 280;
  localparam int HALF_MAX_US    = 32;
  localparam int SHORT_LONG_US  = 25;
  localparam int BROWN_US       = 100;
  localparam int COIL_US        = 100;

  // Derived cycle counts, least times rounded up
  localparam int QUAL_CYC       = (QUAL_NS + CLK_NS - 1) / CLK_NS;
  localparam int DEMAG_CYC      = DEMAG_MS * 1000000 / CLK_NS;
  localparam int ON_DEMAG_CYC   = (ON_DEMAG_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int ON_RUN_CYC     = (ON_RUN_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int ABORT_FILT_CYC = (ABORT_FILT_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC       = (HOLD_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int HALF_MIN_CYC   = (HALF_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int HALF_MAX_CYC   = HALF_MAX_US * 1000 / CLK_NS;
  localparam int SHORT_LONG_CYC = (SHORT_LONG_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int BROWN_CYC      = (BROWN_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int COIL_CYC       = (COIL_US * 1000 + CLK_NS - 1) / CLK_NS;

  // Probe qualification counts
  localparam int GOOD_HALVES    = 8;
  localparam int SHORT_PULSES   = 3;

  // Register map (byte offsets)
  localparam logic [3:0] CTRL_OFF   = 4'h0;
  localparam logic [3:0] STATUS_OFF = 4'h4;

  // Control fields and reset value
  localparam int         CTRL_COIL_ALLOW_BIT = 0;
  localparam logic       CTRL_COIL_ALLOW_RST = 1'h1;

  // Status fields
  localparam int ST_STATE_LSB   = 0;
  localparam int ST_ERROR_BIT   = 3;
  localparam int ST_COMP_BIT    = 4;
  localparam int ST_DEMAG_BIT   = 5;
  localparam int ST_STUCK_BIT   = 6;
  localparam int ST_SHORT_BIT   = 7;
  localparam int ST_OPEN_BIT    = 8;
  localparam int ST_PIN_BIT     = 9;

  typedef enum logic [2:0] {
    DFS_POR     = 3'b000,
    DFS_PWRUP   = 3'b001,
    DFS_DEMAG   = 3'b010,
    DFS_CHECK   = 3'b011,
    DFS_RUN     = 3'b100,
    DFS_STUCK   = 3'b101,
    DFS_SHORTED = 3'b110,
    DFS_HOLD    = 3'b111
  } dfs_mode_t;

endpackage : dfs_pkg

// *** core/dfs_supervisor.sv ***
/*
  Degauss sequencer and fault supervisor: power-on/brown-out sequencing,
  demagnetization cycle, probe oscillation checks, open-coil check,
  open-drain error flag and compensation driver enable, with a classic
  Wishbone slave for control and status.
  Assumes all inputs except arst_n, demag_req and coil_check_enable are
  synchronous to mclk, and that the analog comparators deliver levels.
*/
// Our own choices: the placing of the registers and the Wishbone slave port.
// Contract
// - Demag starts after request high 25.6 us
// - Demag cycle runs about 110 ms
// - Error held low during demag
// - Request high at power-on: demag after 12 us
// - Request low through 25 us filter aborts
// - After abort, error and driver off 3.3 ms
// - Probe oscillator keeps running during demag
// - Request low at power-up: start after 32 us
// - Four good probe cycles release error, driver
// - Power-on and brown-out both at 4 V
// - Below 4 V over 100 us resets
// - Dip to 1.8 V resets immediately
// - Brown-out recovery repeats power-up sequence
// - Probe low over 32 us: error, driver off
// - Stuck-low recovery holds error 3.3 ms
// - Three short pulses fault; long one holds
// - Open coil over 100 us: error only
// - Error is active-low open drain, self-clearing
// - Coil test only when output near ground
`timescale 1ns/1ps
`default_nettype none

module dfs_supervisor #(
  parameter int DEMAG_CYC_P = dfs_pkg::DEMAG_CYC,
  parameter int HOLD_CYC_P  = dfs_pkg::HOLD_CYC,
  parameter int BROWN_CYC_P = dfs_pkg::BROWN_CYC,
  parameter int COIL_CYC_P  = dfs_pkg::COIL_CYC
) (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        demag_req,
  input  wire logic        coil_check_enable,
  input  wire logic        main_supply_above_4v,
  input  wire logic        main_supply_above_1v8,
  input  wire logic        probe_comp,
  input  wire logic        coil_current_low,
  input  wire logic        comp_near_ground,
  input  wire logic        error_i,
  output logic             error_o,
  output logic             error_oe_n,
  output logic             comp_coil_driver_en,
  output logic             demag_active,
  output logic             probe_osc_en,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);

  localparam int TW = 23;

  typedef struct packed {
    dfs_pkg::dfs_mode_t mode;
    logic               demag_s1;
    logic               demag_s2;
    logic               cce_s1;
    logic               cce_s2;
    logic               pwr_demag;
    logic               armed;
    logic [10:0]        hi_cnt;
    logic [10:0]        lo_cnt;
    logic [TW-1:0]      timer;
    logic [TW-1:0]      bo_cnt;
    logic               probe_prev;
    logic [10:0]        half_cnt;
    logic [3:0]         good_cnt;
    logic [1:0]         short_cnt;
    logic               short_flag;
    logic [10:0]        short_dur;
    logic [TW-1:0]      coil_cnt;
    logic               open_coil;
    logic               ctrl_allow;
    logic               ack;
    logic [31:0]        dat;
    logic               err_o;
    logic               err_oe_n;
    logic               comp_en;
    logic               demag_on;
    logic               osc_en;
  } dfs_regs_t;

  dfs_regs_t st_reg;
  dfs_regs_t st_next;
  logic      rst_s1_reg;
  logic      rst_n;

  // Error is released only in clean normal operation
  function automatic logic dfs_clean(input dfs_regs_t s);
    dfs_clean = (s.mode == dfs_pkg::DFS_RUN) && !s.short_flag && !s.open_coil;
  endfunction : dfs_clean

  function automatic logic [TW-1:0] dfs_lim(input int n);
    dfs_lim = TW'(n - 1);
  endfunction : dfs_lim

  // Reset release through two flops
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  logic probe_edge;
  logic good_half;
  logic short_fall;
  logic stuck_now;
  logic coil_cond;
  logic bus_req;

  always_comb
  begin
    st_next    = st_reg;
    probe_edge = probe_comp != st_reg.probe_prev;
    good_half  = probe_edge && (st_reg.half_cnt >= 11'(dfs_pkg::HALF_MIN_CYC - 1))
                 && (st_reg.half_cnt < 11'(dfs_pkg::HALF_MAX_CYC));
    short_fall = probe_edge && st_reg.probe_prev
                 && (st_reg.half_cnt < 11'(dfs_pkg::HALF_MIN_CYC - 1));
    stuck_now  = !probe_comp && (st_reg.half_cnt == 11'(dfs_pkg::HALF_MAX_CYC));
    // test only with an output railed to ground
    coil_cond  = st_reg.cce_s2 && st_reg.ctrl_allow && comp_near_ground
                 && coil_current_low && (st_reg.mode == dfs_pkg::DFS_RUN);
    bus_req    = wb_cyc_i && wb_stb_i;

    st_next.demag_s1 = demag_req;
    st_next.demag_s2 = st_reg.demag_s1;
    st_next.cce_s1   = coil_check_enable;
    st_next.cce_s2   = st_reg.cce_s1;

    // request qualification needs a low phase first
    if (!st_reg.demag_s2)
    begin
      st_next.armed  = 1'b1;
      st_next.hi_cnt = '0;
    end
    else if (st_reg.armed && st_reg.hi_cnt != 11'(dfs_pkg::QUAL_CYC - 1))
    begin
      st_next.hi_cnt = st_reg.hi_cnt + 11'h1;
    end

    if (st_reg.mode == dfs_pkg::DFS_DEMAG && !st_reg.demag_s2)
    begin
      st_next.lo_cnt = st_reg.lo_cnt + 11'h1;
    end
    else
    begin
      st_next.lo_cnt = '0;
    end

    // Probe half-period and short-pulse tracking
    st_next.probe_prev = probe_comp;
    if (probe_edge)
    begin
      st_next.half_cnt = '0;
    end
    else if (st_reg.half_cnt != 11'(dfs_pkg::HALF_MAX_CYC))
    begin
      st_next.half_cnt = st_reg.half_cnt + 11'h1;
    end
    if (short_fall)
    begin
      if (st_reg.short_cnt == 2'(dfs_pkg::SHORT_PULSES - 1))
      begin
        st_next.short_flag = 1'b1;
      end
      else
      begin
        st_next.short_cnt = st_reg.short_cnt + 2'h1;
      end
    end
    else if (probe_edge && st_reg.probe_prev)
    begin
      st_next.short_cnt  = '0;
      st_next.short_flag = 1'b0;
    end
    if (st_reg.short_flag && st_reg.short_dur != 11'(dfs_pkg::SHORT_LONG_CYC))
    begin
      st_next.short_dur = st_reg.short_dur + 11'h1;
    end
    else if (!st_reg.short_flag)
    begin
      st_next.short_dur = '0;
    end

    if (st_reg.mode != dfs_pkg::DFS_CHECK)
    begin
      st_next.good_cnt = '0;
    end
    else if (probe_edge)
    begin
      st_next.good_cnt = good_half ? st_reg.good_cnt + 4'h1 : 4'h0;
    end

    if (!coil_cond)
    begin
      st_next.coil_cnt  = '0;
      st_next.open_coil = 1'b0;
    end
    else if (st_reg.coil_cnt == dfs_lim(COIL_CYC_P))
    begin
      st_next.open_coil = 1'b1;
    end
    else
    begin
      st_next.coil_cnt = st_reg.coil_cnt + TW'(1);
    end

    // one 4 V level for both detections
    if (!main_supply_above_4v && st_reg.mode != dfs_pkg::DFS_POR)
    begin
      st_next.bo_cnt = st_reg.bo_cnt + TW'(1);
    end
    else
    begin
      st_next.bo_cnt = '0;
    end

    case (st_reg.mode)
      dfs_pkg::DFS_POR:
      begin
        if (main_supply_above_4v)
        begin
          st_next.mode      = dfs_pkg::DFS_PWRUP;
          st_next.pwr_demag = st_reg.demag_s2;
        end
      end
      dfs_pkg::DFS_PWRUP:
      begin
        if (st_reg.pwr_demag && st_reg.timer == dfs_lim(dfs_pkg::ON_DEMAG_CYC))
        begin
          st_next.mode = dfs_pkg::DFS_DEMAG;
        end
        else if (!st_reg.pwr_demag && st_reg.timer == dfs_lim(dfs_pkg::ON_RUN_CYC))
        begin
          st_next.mode = dfs_pkg::DFS_CHECK;
        end
      end
      dfs_pkg::DFS_DEMAG:
      begin
        if (!st_reg.demag_s2 && st_reg.lo_cnt == 11'(dfs_pkg::ABORT_FILT_CYC - 1))
        begin
          st_next.mode = dfs_pkg::DFS_HOLD;
        end
        else if (st_reg.timer == dfs_lim(DEMAG_CYC_P))
        begin
          st_next.mode = dfs_pkg::DFS_CHECK;
        end
      end
      dfs_pkg::DFS_CHECK:
      begin
        if (good_half && st_reg.good_cnt == 4'(dfs_pkg::GOOD_HALVES - 1))
        begin
          st_next.mode = dfs_pkg::DFS_RUN;
        end
      end
      dfs_pkg::DFS_RUN:
      begin
        if (st_reg.armed && st_reg.demag_s2
            && st_reg.hi_cnt == 11'(dfs_pkg::QUAL_CYC - 1))
        begin
          st_next.mode = dfs_pkg::DFS_DEMAG;
        end
        else if (stuck_now)
        begin
          st_next.mode = dfs_pkg::DFS_STUCK;
        end
        // fault past 25 us interrupts the driver
        else if (st_reg.short_flag
                 && st_reg.short_dur == 11'(dfs_pkg::SHORT_LONG_CYC))
        begin
          st_next.mode = dfs_pkg::DFS_SHORTED;
        end
      end
      dfs_pkg::DFS_STUCK:
      begin
        if (probe_comp)
        begin
          st_next.mode = dfs_pkg::DFS_HOLD;
        end
      end
      dfs_pkg::DFS_SHORTED:
      begin
        if (!st_reg.short_flag)
        begin
          st_next.mode = dfs_pkg::DFS_HOLD;
        end
      end
      dfs_pkg::DFS_HOLD:
      begin
        if (st_reg.timer == dfs_lim(HOLD_CYC_P))
        begin
          st_next.mode = dfs_pkg::DFS_RUN;
        end
      end
      default:
      begin
        st_next.mode = dfs_pkg::DFS_POR;
      end
    endcase

    // long brown-out; deep dip; restart from power-up
    if (!main_supply_above_1v8
        || (!main_supply_above_4v && st_reg.bo_cnt == dfs_lim(BROWN_CYC_P)))
    begin
      st_next.mode = dfs_pkg::DFS_POR;
    end

    if (st_next.mode == dfs_pkg::DFS_DEMAG)
    begin
      st_next.armed = 1'b0;
    end
    st_next.timer = (st_next.mode != st_reg.mode) ? '0 : st_reg.timer + TW'(1);

    // error open drain, pulled low unless clean
    st_next.err_o    = 1'b0;
    st_next.err_oe_n = dfs_clean(st_next);
    st_next.comp_en  = st_next.mode == dfs_pkg::DFS_RUN;
    st_next.demag_on = st_next.mode == dfs_pkg::DFS_DEMAG;
    // oscillator runs in every powered state
    st_next.osc_en   = st_next.mode != dfs_pkg::DFS_POR;

    // Classic Wishbone: one wait state, write lands with ack
    st_next.ack = bus_req && !st_reg.ack;
    st_next.dat = '0;
    if (bus_req && !st_reg.ack && !wb_we_i)
    begin
      if (wb_adr_i == dfs_pkg::CTRL_OFF)
      begin
        st_next.dat[dfs_pkg::CTRL_COIL_ALLOW_BIT] = st_reg.ctrl_allow;
      end
      else if (wb_adr_i == dfs_pkg::STATUS_OFF)
      begin
        st_next.dat[dfs_pkg::ST_STATE_LSB +: 3] = st_reg.mode;
        st_next.dat[dfs_pkg::ST_ERROR_BIT]      = !st_reg.err_oe_n;
        st_next.dat[dfs_pkg::ST_COMP_BIT]       = st_reg.comp_en;
        st_next.dat[dfs_pkg::ST_DEMAG_BIT]      = st_reg.demag_on;
        st_next.dat[dfs_pkg::ST_STUCK_BIT]      = st_reg.mode == dfs_pkg::DFS_STUCK;
        st_next.dat[dfs_pkg::ST_SHORT_BIT]      = st_reg.short_flag;
        st_next.dat[dfs_pkg::ST_OPEN_BIT]       = st_reg.open_coil;
        st_next.dat[dfs_pkg::ST_PIN_BIT]        = error_i;
      end
    end
    if (bus_req && st_reg.ack && wb_we_i && wb_sel_i[0]
        && wb_adr_i == dfs_pkg::CTRL_OFF)
    begin
      st_next.ctrl_allow = wb_dat_i[dfs_pkg::CTRL_COIL_ALLOW_BIT];
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg            <= '0;
      st_reg.mode       <= dfs_pkg::DFS_POR;
      st_reg.err_oe_n   <= 1'b0;
      st_reg.ctrl_allow <= dfs_pkg::CTRL_COIL_ALLOW_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign error_o             = st_reg.err_o;
  assign error_oe_n          = st_reg.err_oe_n;
  assign comp_coil_driver_en = st_reg.comp_en;
  assign demag_active        = st_reg.demag_on;
  assign probe_osc_en        = st_reg.osc_en;
  assign wb_dat_o            = st_reg.dat;
  assign wb_ack_o            = st_reg.ack;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  demag_start_qual_a: assert property (
    $past(st_reg.mode) == dfs_pkg::DFS_RUN && st_reg.mode == dfs_pkg::DFS_DEMAG
    |-> $past(st_reg.hi_cnt) == 11'(dfs_pkg::QUAL_CYC - 1) && $past(st_reg.demag_s2))
    else $error("Demag started without qualified request");

  demag_length_a: assert property (
    $past(st_reg.mode) == dfs_pkg::DFS_DEMAG && st_reg.mode == dfs_pkg::DFS_CHECK
    |-> $past(st_reg.timer) == dfs_lim(DEMAG_CYC_P))
    else $error("Demag cycle ended at wrong time");

  demag_error_a: assert property (
    demag_active |-> !error_oe_n && !comp_coil_driver_en)
    else $error("Error released during demag");

  pwrup_demag_a: assert property (
    $past(st_reg.mode) == dfs_pkg::DFS_PWRUP && st_reg.mode == dfs_pkg::DFS_DEMAG
    |-> $past(st_reg.pwr_demag) && $past(st_reg.timer) == dfs_lim(dfs_pkg::ON_DEMAG_CYC))
    else $error("Power-on demag at wrong time");

  abort_filter_a: assert property (
    $past(st_reg.mode) == dfs_pkg::DFS_DEMAG && st_reg.mode == dfs_pkg::DFS_HOLD
    |-> $past(st_reg.lo_cnt) == 11'(dfs_pkg::ABORT_FILT_CYC - 1))
    else $error("Abort taken before glitch filter");

  // Outputs are registered with the mode, so they are checked in the same cycle
  hold_outputs_a: assert property (
    st_reg.mode == dfs_pkg::DFS_HOLD |-> !error_oe_n && !comp_coil_driver_en)
    else $error("Hold did not keep error and driver off");

  osc_running_a: assert property (
    demag_active |-> probe_osc_en)
    else $error("Oscillator stopped during demag");

  pwrup_run_a: assert property (
    $past(st_reg.mode) == dfs_pkg::DFS_PWRUP && st_reg.mode == dfs_pkg::DFS_CHECK
    |-> !$past(st_reg.pwr_demag) && $past(st_reg.timer) == dfs_lim(dfs_pkg::ON_RUN_CYC))
    else $error("Power-up start at wrong time");

  check_release_a: assert property (
    $past(st_reg.mode) == dfs_pkg::DFS_CHECK && st_reg.mode == dfs_pkg::DFS_RUN
    |-> $past(st_reg.good_cnt) == 4'(dfs_pkg::GOOD_HALVES - 1))
    else $error("Driver enabled before four good cycles");

  deep_dip_a: assert property (
    !main_supply_above_1v8 |=> st_reg.mode == dfs_pkg::DFS_POR ##1 !error_oe_n)
    else $error("Deep dip did not reset");

  brownout_a: assert property (
    $past(st_reg.mode) != dfs_pkg::DFS_POR && st_reg.mode == dfs_pkg::DFS_POR
    && $past(main_supply_above_1v8)
    |-> $past(st_reg.bo_cnt) == dfs_lim(BROWN_CYC_P))
    else $error("Brown-out reset at wrong count");

  stuck_driver_a: assert property (
    st_reg.mode == dfs_pkg::DFS_STUCK |=> !comp_coil_driver_en && !error_oe_n)
    else $error("Stuck probe left driver on");

  open_coil_a: assert property (
    st_reg.open_coil && st_reg.mode == dfs_pkg::DFS_RUN
    |-> !st_reg.err_oe_n && st_reg.comp_en)
    else $error("Open coil handled wrongly");

  clean_release_a: assert property (
    dfs_clean(st_reg) |-> error_oe_n && error_o == 1'b0)
    else $error("Error not released in clean run");

  demag_done_c: cover property (
    $past(st_reg.mode) == dfs_pkg::DFS_DEMAG && st_reg.mode == dfs_pkg::DFS_CHECK);
  demag_abort_c: cover property (
    $past(st_reg.mode) == dfs_pkg::DFS_DEMAG && st_reg.mode == dfs_pkg::DFS_HOLD);
  stuck_recover_c: cover property (
    $past(st_reg.mode) == dfs_pkg::DFS_STUCK && st_reg.mode == dfs_pkg::DFS_HOLD);
  open_coil_c: cover property (st_reg.open_coil);

endmodule : dfs_supervisor

`default_nettype wire

// *** tb/dfs_partner.sv ***
/*
  Far-side model: probe comparator source and the pulled-up error wire.
  Assumes the bench sets the probe half period in clock cycles, 0 = stuck low.
*/
`timescale 1ns/1ps
`default_nettype none

module dfs_partner (
  input  wire logic        mclk,
  input  wire logic [10:0] half,
  input  wire logic        error_o,
  input  wire logic        error_oe_n,
  output logic             probe_comp,
  output logic             err_w
);
  logic [10:0] cnt_reg;

  initial probe_comp = 1'b0;
  initial cnt_reg = 11'h000;

  assign err_w = error_oe_n ? 1'b1 : error_o;

  always @(posedge mclk)
  begin
    if (half == 11'h000)
    begin
      probe_comp <= 1'b0;
      cnt_reg    <= 11'h000;
    end
    else if (cnt_reg >= half - 11'h001)
    begin
      probe_comp <= ~probe_comp;
      cnt_reg    <= 11'h000;
    end
    else
      cnt_reg <= cnt_reg + 11'h001;
  end
endmodule : dfs_partner

`default_nettype wire

// *** tb/dfs_supervisor_tb.sv ***
/*
  Self-checking bench for the supervisor with shortened counts.
  Assumes the partner model supplies the probe and the error pull-up.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin fails++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, a); end end

module dfs_supervisor_tb;
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic        demag_req = 1'b0;
  logic        coil_en = 1'b1;
  logic        above_4v = 1'b1;
  logic        above_1v8 = 1'b1;
  logic        coil_low = 1'b0;
  logic        near_gnd = 1'b0;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [10:0] half = 11'h032;
  wire logic   error_o, error_oe_n, comp_en, demag_act, osc_en, probe, err_w, ack;
  wire logic [31:0] rdat;
  int          fails = 0;
  int          n_checks = 0;
  int          cycles = 0;

  // Demag must outlast the 1250-cycle abort filter
  dfs_supervisor #(.DEMAG_CYC_P(3000), .HOLD_CYC_P(100), .BROWN_CYC_P(50), .COIL_CYC_P(50))
  i_dut (.mclk(mclk), .arst_n(arst_n), .demag_req(demag_req), .coil_check_enable(coil_en),
    .main_supply_above_4v(above_4v), .main_supply_above_1v8(above_1v8),
    .probe_comp(probe), .coil_current_low(coil_low), .comp_near_ground(near_gnd),
    .error_i(err_w), .error_o(error_o), .error_oe_n(error_oe_n),
    .comp_coil_driver_en(comp_en), .demag_active(demag_act), .probe_osc_en(osc_en),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));

  dfs_partner i_far (.mclk(mclk), .half(half), .error_o(error_o),
    .error_oe_n(error_oe_n), .probe_comp(probe), .err_w(err_w));

  always #10 mclk = ~mclk;

  // Run is about 25k cycles; ceiling leaves margin
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      fails++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
  endtask : tick

  function automatic logic pick(input int w);
    case (w)
      0: pick = err_w;
      1: pick = demag_act;
      default: pick = comp_en;
    endcase
  endfunction : pick

  // Bounded wait; n is cycles taken
  task automatic wait_on(input int w, input logic v, input int lim, output int n);
    n = 0;
    while (pick(w) !== v && n < lim)
    begin
      @(posedge mclk);
      n++;
    end
  endtask : wait_on

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge mclk);
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    // Ends on ack; with no bound here, only the bench timeout ends a hang
    do
    begin
      @(posedge mclk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    @(posedge mclk);
  endtask : wb

  task automatic t_regs();
    logic [31:0] q;
    wb(1'b0, 4'h0, 32'h0, q);
    `CHK("ctrl_rst", 32'h1, q)
    wb(1'b1, 4'h0, 32'h0, q);
    wb(1'b0, 4'h0, 32'h0, q);
    `CHK("ctrl_wr", 32'h0, q)
    wb(1'b1, 4'h0, 32'hffffffff, q);
    wb(1'b1, 4'h4, 32'h0, q);
    wb(1'b0, 4'h0, 32'h0, q);
    `CHK("ctrl_bit0", 32'h1, q)
    wb(1'b0, 4'h4, 32'h0, q);
    `CHK("st_run", 5'h14, q[4:0])
    `CHK("st_pin", 1'b1, q[9])
    wb(1'b0, 4'h8, 32'h0, q);
    `CHK("unmapped", 32'h0, q)
  endtask : t_regs

  task automatic t_demag();
    int n;
    demag_req <= 1'b1;
    tick(1000);
    demag_req <= 1'b0;
    tick(1400);
    `CHK("short_req", 1'b0, demag_act)
    demag_req <= 1'b1;
    wait_on(1, 1'b1, 2000, n);
    `CHK("qual", 1'b1, n >= 1280 && n < 1290)
    `CHK("err_dm", 1'b0, err_w)
    `CHK("osc_dm", 1'b1, osc_en)
    wait_on(1, 1'b0, 4000, n);
    `CHK("dm_len", 1'b1, n >= 2995 && n <= 3005)
    `CHK("err_end", 1'b0, err_w)
    wait_on(0, 1'b1, 2000, n);
    `CHK("dm_ready", 1'b1, n < 2000)
    tick(1500);
    `CHK("retrig", 1'b0, demag_act)
    demag_req <= 1'b0;
    tick(10);
    demag_req <= 1'b1;
    wait_on(1, 1'b1, 2000, n);
    tick(50);
    demag_req <= 1'b0;
    wait_on(1, 1'b0, 2000, n);
    `CHK("abort_filt", 1'b1, n >= 1250 && n < 1260)
    `CHK("abort_err", 1'b0, err_w)
    `CHK("abort_comp", 1'b0, comp_en)
    wait_on(0, 1'b1, 400, n);
    `CHK("abort_hold", 1'b1, n >= 99 && n < 110)
  endtask : t_demag

  task automatic t_probe();
    int n;
    half <= 11'h000;
    tick(1000);
    `CHK("stuck_comp", 1'b1, comp_en)
    wait_on(0, 1'b0, 1000, n);
    `CHK("stuck_t", 1'b1, n >= 550 && n < 610)
    `CHK("stuck_off", 1'b0, comp_en)
    half <= 11'h032;
    wait_on(0, 1'b1, 1000, n);
    `CHK("stuck_hold", 1'b1, n >= 100 && n < 200)
    half <= 11'h005;
    wait_on(0, 1'b0, 200, n);
    `CHK("short_flag", 1'b1, n < 200)
    half <= 11'h014;
    wait_on(0, 1'b1, 200, n);
    `CHK("short_quick", 1'b1, n < 100)
    `CHK("short_comp", 1'b1, comp_en)
    half <= 11'h005;
    tick(1400);
    `CHK("short_long", 1'b0, comp_en)
    half <= 11'h014;
    wait_on(0, 1'b1, 400, n);
    `CHK("short_hold", 1'b1, n >= 100 && n < 200)
  endtask : t_probe

  task automatic t_coil();
    int n;
    logic [31:0] q;
    coil_low <= 1'b1;
    near_gnd <= 1'b1;
    wait_on(0, 1'b0, 200, n);
    `CHK("open_t", 1'b1, n >= 50 && n < 60)
    `CHK("open_comp", 1'b1, comp_en)
    coil_low <= 1'b0;
    wait_on(0, 1'b1, 20, n);
    `CHK("open_clr", 1'b1, n < 20)
    near_gnd <= 1'b0;
    coil_low <= 1'b1;
    tick(200);
    `CHK("not_gnd", 1'b1, err_w)
    near_gnd <= 1'b1;
    coil_en <= 1'b0;
    tick(200);
    `CHK("pin_off", 1'b1, err_w)
    coil_en <= 1'b1;
    wb(1'b1, 4'h0, 32'h0, q);
    tick(200);
    `CHK("ctrl_off", 1'b1, err_w)
    wb(1'b1, 4'h0, 32'h1, q);
    coil_low <= 1'b0;
  endtask : t_coil

  task automatic t_brown();
    int n;
    above_4v <= 1'b0;
    tick(30);
    above_4v <= 1'b1;
    tick(5);
    `CHK("brief_dip", 1'b1, err_w)
    demag_req <= 1'b1;
    above_4v <= 1'b0;
    tick(60);
    `CHK("brown_err", 1'b0, err_w)
    above_4v <= 1'b1;
    wait_on(1, 1'b1, 1000, n);
    `CHK("pwr_demag", 1'b1, n >= 600 && n < 610)
    wait_on(0, 1'b1, 4000, n);
    `CHK("brown_rdy", 1'b1, n < 4000)
    demag_req <= 1'b0;
    tick(5);
    above_1v8 <= 1'b0;
    tick(1);
    above_1v8 <= 1'b1;
    tick(2);
    `CHK("dip_1v8", 1'b0, err_w)
    wait_on(0, 1'b1, 5000, n);
    `CHK("dip_rdy", 1'b1, n > 1600 && n < 5000)
  endtask : t_brown

  initial
  begin
    int n;
    tick(5);
    arst_n <= 1'b1;
    wait_on(0, 1'b1, 5000, n);
    `CHK("pwrup_t", 1'b1, n > 1600 && n < 2600)
    `CHK("pwrup_comp", 1'b1, comp_en)
    `CHK("pwrup_dm", 1'b0, demag_act)
    t_regs();
    t_demag();
    t_probe();
    t_coil();
    t_brown();
    report_and_stop();
  end
endmodule : dfs_supervisor_tb

`default_nettype wire
